// file: sram_boundary_scan_tap.sv
/*
 Boundary scan test port of a pipelined burst SRAM: controller, instruction,
 bypass, identification and boundary registers. The test logic runs on tck;
 only the output-float request crosses into the memory clock domain.
 Assumes the bench resolves the serial output wire from tdo_oe_b and reports
 whether tms and tdi are actually driven.
*/
// Operation
// - Sample on rising, launch on falling edge
// - Undriven mode-select and data read high
// - Shift in at MSB, out LSB
// - Output enable per state, falling edge
// - Five high mode-select edges reset controller
// - Power-up reset, serial output floats
// - Three-bit instruction, preset to identification
// - Capture-instruction loads 01 low bits
// - One register in path, chosen by instruction
// - One-bit bypass, cleared on bypass
// - Bypass in path during shift-data
// - Boundary register captures ring, shifts
// - Identification value captured then shifted out
// - Never drive memory; only capture ring
// - Shift instruction, effective at update
// - All-zero code samples and floats outputs
// - Sample-with-float: boundary path, outputs float
// - Sample/preload snapshots pins at capture
// - Capture-out and preload-in shift together
// - Code 001 identification, 010 sample-float
// - Identification bit 0 reads one
// - Boundary register is 69 bits
`timescale 1ns/1ps

module sram_boundary_scan_tap #(
   parameter int BSR_LEN = tap_pkg::BSR_WIDTH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic tck,
   input wire logic tms,
   input wire logic tms_driven,
   input wire logic tdi,
   input wire logic tdi_driven,
   input wire logic memory_clock_true,
   input wire logic memory_clock_comp,
   input wire logic [BSR_LEN-3:0] ring_in,
   output logic tdo,
   output logic tdo_oe_b,
   output logic mem_outputs_hiz
);

   // ****************************************************
   // Pin inputs on tck
   // ****************************************************
   logic tms_eff;
   logic tdi_eff;
   logic [BSR_LEN-1:0] ring_meta_reg;
   logic [BSR_LEN-1:0] ring_sync_reg;
   logic [BSR_LEN-1:0] ring_meta_next;
   logic [BSR_LEN-1:0] ring_sync_next;

   // Pull-ups: a floating ball reads high
   assign tms_eff = tms_driven ? tms : 1'b1;
   assign tdi_eff = tdi_driven ? tdi : 1'b1;

   // Ring is asynchronous to tck; captures stay only as good as the pins
   always_comb
   begin
      ring_meta_next = {memory_clock_true, memory_clock_comp, ring_in};
      ring_sync_next = ring_meta_reg;
   end

   always_ff @(posedge tck or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ring_meta_reg <= '0;
         ring_sync_reg <= '0;
      end
      else
      begin
         ring_meta_reg <= ring_meta_next;
         ring_sync_reg <= ring_sync_next;
      end
   end

   // ****************************************************
   // Controller
   // ****************************************************
   tap_pkg::tap_state_e state_reg;
   tap_pkg::tap_state_e state_next;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         tap_pkg::ST_RESET:
            state_next = tms_eff ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
         tap_pkg::ST_IDLE:
            state_next = tms_eff ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         tap_pkg::ST_SEL_DR:
            state_next = tms_eff ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
         tap_pkg::ST_CAP_DR:
            state_next = tms_eff ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
         tap_pkg::ST_SH_DR:
            state_next = tms_eff ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
         tap_pkg::ST_EX1_DR:
            state_next = tms_eff ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR;
         tap_pkg::ST_PAUSE_DR:
            state_next = tms_eff ? tap_pkg::ST_EX2_DR : tap_pkg::ST_PAUSE_DR;
         tap_pkg::ST_EX2_DR:
            state_next = tms_eff ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SH_DR;
         tap_pkg::ST_UPD_DR:
            state_next = tms_eff ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         tap_pkg::ST_SEL_IR:
            state_next = tms_eff ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
         tap_pkg::ST_CAP_IR:
            state_next = tms_eff ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
         tap_pkg::ST_SH_IR:
            state_next = tms_eff ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
         tap_pkg::ST_EX1_IR:
            state_next = tms_eff ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR;
         tap_pkg::ST_PAUSE_IR:
            state_next = tms_eff ? tap_pkg::ST_EX2_IR : tap_pkg::ST_PAUSE_IR;
         tap_pkg::ST_EX2_IR:
            state_next = tms_eff ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SH_IR;
         tap_pkg::ST_UPD_IR:
            state_next = tms_eff ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
         default:
            state_next = tap_pkg::ST_RESET;
      endcase
   end

   // Power-up lands in the reset state; memory side is untouched
   always_ff @(posedge tck or negedge rst_b)
   begin
      if (!rst_b)
         state_reg <= tap_pkg::ST_RESET;
      else
         state_reg <= state_next;
   end

   // ****************************************************
   // Instruction register and decode
   // ****************************************************
   logic [tap_pkg::IR_WIDTH-1:0] ir_shift_reg;
   logic [tap_pkg::IR_WIDTH-1:0] ir_shift_next;
   logic [tap_pkg::IR_WIDTH-1:0] ir_reg;
   logic [tap_pkg::IR_WIDTH-1:0] ir_next;
   tap_pkg::decode_s dec;

   always_comb
   begin
      ir_shift_next = ir_shift_reg;
      ir_next = ir_reg;
      case (state_reg)
         tap_pkg::ST_RESET:
         begin
            ir_shift_next = tap_pkg::IR_RESET;
            ir_next = tap_pkg::IR_RESET;
         end
         tap_pkg::ST_CAP_IR:
            ir_shift_next = tap_pkg::IR_CAPTURE;
         tap_pkg::ST_SH_IR:
            ir_shift_next = {tdi_eff, ir_shift_reg[2:1]};
         tap_pkg::ST_UPD_IR:
            ir_next = ir_shift_reg;
         default:
            ir_next = ir_reg;
      endcase
   end

   always_ff @(posedge tck or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ir_shift_reg <= tap_pkg::IR_RESET;
         ir_reg <= tap_pkg::IR_RESET;
      end
      else
      begin
         ir_shift_reg <= ir_shift_next;
         ir_reg <= ir_next;
      end
   end

   // Reserved codes fall back to bypass so the chain stays intact
   always_comb
   begin
      dec = '0;
      case (ir_reg)
         tap_pkg::INSTR_EXTEST:
         begin
            dec.sel_bsr = 1'b1;
            dec.force_hiz = 1'b1;
         end
         tap_pkg::INSTR_IDCODE:
            dec.sel_id = 1'b1;
         tap_pkg::INSTR_SAMPLE_Z:
         begin
            dec.sel_bsr = 1'b1;
            dec.force_hiz = 1'b1;
         end
         tap_pkg::INSTR_SAMPLE:
            dec.sel_bsr = 1'b1;
         default:
            dec.sel_byp = 1'b1;
      endcase
   end

   // ****************************************************
   // Data registers
   // ****************************************************
   // Hardwired; only bit 0 carries meaning
   localparam logic [tap_pkg::ID_WIDTH-1:0] ID_VALUE = {
      tap_pkg::ID_REVISION, tap_pkg::ID_DEVICE,
      tap_pkg::ID_VENDOR, tap_pkg::ID_PRESENT};

   logic byp_reg;
   logic byp_next;
   logic [tap_pkg::ID_WIDTH-1:0] id_reg;
   logic [tap_pkg::ID_WIDTH-1:0] id_next;
   logic [BSR_LEN-1:0] bsr_reg;
   logic [BSR_LEN-1:0] bsr_next;

   always_comb
   begin
      byp_next = byp_reg;
      id_next = id_reg;
      bsr_next = bsr_reg;
      case (state_reg)
         tap_pkg::ST_CAP_DR:
         begin
            if (dec.sel_byp)
               byp_next = tap_pkg::BYPASS_CAPTURE;
            if (dec.sel_id)
               id_next = ID_VALUE;
            // Capture only: nothing is ever driven back into the SRAM
            if (dec.sel_bsr)
               bsr_next = ring_sync_reg;
         end
         tap_pkg::ST_SH_DR:
         begin
            if (dec.sel_byp)
               byp_next = tdi_eff;
            if (dec.sel_id)
               id_next = {tdi_eff, id_reg[tap_pkg::ID_WIDTH-1:1]};
            // Captured bits leave while preload bits enter
            if (dec.sel_bsr)
               bsr_next = {tdi_eff, bsr_reg[BSR_LEN-1:1]};
         end
         // Bypass bit clears as the instruction takes effect
         tap_pkg::ST_UPD_IR:
            if (ir_shift_reg == tap_pkg::INSTR_BYPASS)
               byp_next = tap_pkg::BYPASS_CAPTURE;
         default:
            byp_next = byp_reg;
      endcase
   end

   always_ff @(posedge tck or negedge rst_b)
   begin
      if (!rst_b)
      begin
         byp_reg <= tap_pkg::BYPASS_CAPTURE;
         id_reg <= '0;
         bsr_reg <= '0;
      end
      else
      begin
         byp_reg <= byp_next;
         id_reg <= id_next;
         bsr_reg <= bsr_next;
      end
   end

   // ****************************************************
   // Serial output, falling edge
   // ****************************************************
   logic tdo_next;
   logic tdo_oe_b_next;

   always_comb
   begin
      // Value held while floating saves a needless toggle
      tdo_next = tdo;
      tdo_oe_b_next = 1'b1;
      if (state_reg == tap_pkg::ST_SH_IR)
      begin
         tdo_next = ir_shift_reg[0];
         tdo_oe_b_next = 1'b0;
      end
      else if (state_reg == tap_pkg::ST_SH_DR)
      begin
         tdo_oe_b_next = 1'b0;
         if (dec.sel_bsr)
            tdo_next = bsr_reg[0];
         else if (dec.sel_id)
            tdo_next = id_reg[0];
         else
            tdo_next = byp_reg;
      end
   end

   // Half a tck of hold for the next device in the chain
   always_ff @(negedge tck or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tdo <= 1'b0;
         tdo_oe_b <= 1'b1;
      end
      else
      begin
         tdo <= tdo_next;
         tdo_oe_b <= tdo_oe_b_next;
      end
   end

   // ****************************************************
   // Output-float request into memory clock domain
   // ****************************************************
   logic hiz_tck_reg;
   logic hiz_tck_next;
   logic hiz_meta_reg;
   logic hiz_meta_next;
   logic hiz_next;

   // Registered at source so only a glitch-free level crosses
   // Follows the instruction as it loads: tck may stop right after
   always_comb
   begin
      hiz_tck_next = dec.force_hiz;
      if (state_reg == tap_pkg::ST_RESET)
         hiz_tck_next = 1'b0;
      else if (state_reg == tap_pkg::ST_UPD_IR)
         hiz_tck_next = (ir_shift_reg == tap_pkg::INSTR_EXTEST) ||
            (ir_shift_reg == tap_pkg::INSTR_SAMPLE_Z);
   end

   always_ff @(posedge tck or negedge rst_b)
   begin
      if (!rst_b)
         hiz_tck_reg <= 1'b0;
      else
         hiz_tck_reg <= hiz_tck_next;
   end

   always_comb
   begin
      hiz_meta_next = hiz_tck_reg;
      hiz_next = hiz_meta_reg;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hiz_meta_reg <= 1'b0;
         mem_outputs_hiz <= 1'b0;
      end
      else
      begin
         hiz_meta_reg <= hiz_meta_next;
         mem_outputs_hiz <= hiz_next;
      end
   end

endmodule

// file: tap_pkg.sv
/*
 Shared constants and types of the SRAM boundary scan test port.
 Assumes a standard sixteen-state test controller and a three-bit
 instruction register; no software-visible registers.
*/
package tap_pkg;

   // ****************************************************
   // Widths
   // ****************************************************
   localparam int IR_WIDTH = 3;
   localparam int ID_WIDTH = 32;
   localparam int BSR_WIDTH = 69;
   localparam int SYNC_STAGES = 2;

   // ****************************************************
   // Instruction codes
   // ****************************************************
   localparam logic [2:0] INSTR_EXTEST = 3'h0;
   localparam logic [2:0] INSTR_IDCODE = 3'h1;
   localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
   localparam logic [2:0] INSTR_SAMPLE = 3'h4;
   localparam logic [2:0] INSTR_BYPASS = 3'h7;

   // ****************************************************
   // Reset and capture values
   // ****************************************************
   localparam logic [2:0] IR_RESET = INSTR_IDCODE;
   localparam logic [2:0] IR_CAPTURE = 3'h1;
   localparam logic BYPASS_CAPTURE = 1'b0;
   localparam logic ID_PRESENT = 1'b1;

   // Identification fields, values arbitrary
   localparam logic [2:0] ID_REVISION = 3'h5;
   localparam logic [16:0] ID_DEVICE = 17'h0_1234;
   localparam logic [10:0] ID_VENDOR = 11'h2AB;

   // ****************************************************
   // Types
   // ****************************************************
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE,
      ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
      ST_PAUSE_DR, ST_EX2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
      ST_PAUSE_IR, ST_EX2_IR, ST_UPD_IR
   } tap_state_e;

   typedef struct packed {
      logic sel_bsr;
      logic sel_id;
      logic sel_byp;
      logic force_hiz;
   } decode_s;

endpackage

// file: sram_boundary_scan_tap_chk.sv
/*
 Checker of the scan test port: serial output timing, enable and reset.
 Assumes tck idles low between frames and is slower than clk.
*/
`timescale 1ns/1ps
module sram_boundary_scan_tap_chk #(
   parameter int BSR_LEN = tap_pkg::BSR_WIDTH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic tck,
   input wire logic tms,
   input wire logic tms_driven,
   input wire logic tdi,
   input wire logic tdi_driven,
   input wire logic memory_clock_true,
   input wire logic memory_clock_comp,
   input wire logic [BSR_LEN-3:0] ring_in,
   input wire logic tdo,
   input wire logic tdo_oe_b,
   input wire logic mem_outputs_hiz
);
   // ******
   // Mode-select history, newest in bit 0
   // ******
   logic [9:0] hist_reg;
   logic [9:0] hist_next;
   always_comb
   begin
      hist_next = {hist_reg[8:0], tms | !tms_driven};
   end
   always_ff @(posedge tck or negedge rst_b)
   begin
      if (!rst_b)
         hist_reg <= 10'h000;
      else
         hist_reg <= hist_next;
   end
   sequence s_id_first;
      !tdo_oe_b && tdo;
   endsequence
   sequence s_ir_capture;
      (!tdo_oe_b && tdo) ##1 !tdo;
   endsequence
   // ******
   // Properties
   // ******
   a_tdo_fall_launch: assert property (
      @(posedge clk) disable iff (!rst_b) $changed(tdo) |-> !tck)
      else $error("tdo changed with tck high");
   a_oe_fall_launch: assert property (
      @(posedge clk) disable iff (!rst_b) $changed(tdo_oe_b) |-> !tck)
      else $error("tdo enable changed with tck high");
   a_reset_quiet: assert property (
      @(posedge clk) disable iff (!rst_b)
      $rose(rst_b) |-> tdo_oe_b && !mem_outputs_hiz)
      else $error("bad outputs after reset");
   a_oe_needs_zero: assert property (
      @(posedge tck) disable iff (!rst_b)
      !tdo_oe_b |-> hist_reg[1:0] == 2'h0)
      else $error("tdo driven outside shift");
   a_shift_leave: assert property (
      @(posedge tck) disable iff (!rst_b) hist_reg[0] |-> tdo_oe_b)
      else $error("tdo driven after leaving shift");
   a_reset_idcode: assert property (
      @(posedge tck) disable iff (!rst_b)
      hist_reg[8:0] == 9'h1F4 |-> s_id_first)
      else $error("no id bit after tap reset");
   a_ir_capture: assert property (
      @(posedge tck) disable iff (!rst_b)
      hist_reg == 10'h3EC |-> s_ir_capture)
      else $error("bad instruction capture");
   a_reset_unfloat: assert property (
      @(posedge tck) disable iff (!rst_b)
      hist_reg[4:0] == 5'h1F |-> ##2 !mem_outputs_hiz)
      else $error("float kept after tap reset");
endmodule

bind sram_boundary_scan_tap sram_boundary_scan_tap_chk #(.BSR_LEN(BSR_LEN))
   chk (.clk, .rst_b, .tck, .tms, .tms_driven, .tdi, .tdi_driven,
   .memory_clock_true, .memory_clock_comp, .ring_in, .tdo, .tdo_oe_b,
   .mem_outputs_hiz);

// file: jtag_host_model.sv
/*
 Board scan controller model driving the test port pins.
 Assumes callers serialise its tasks; tck stands low between frames.
*/
`timescale 1ns/1ps
module jtag_host_model (
   output logic tck,
   output logic tms,
   output logic tms_driven,
   output logic tdi,
   output logic tdi_driven,
   input wire logic tdo,
   input wire logic tdo_oe_b
);
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tms_driven = 1'b1;
      tdi = 1'b0;
      tdi_driven = 1'b1;
   end
   // One 48 ns period, output read at the rising edge
   task automatic step(input logic m, input logic d, output logic o,
      output logic e);
      tms <= m;
      tdi <= d;
      #24 tck <= 1'b1;
      // A floating output shows the inverse of its last value
      o = tdo_oe_b ? !tdo : tdo;
      e = tdo_oe_b;
      #24 tck <= 1'b0;
   endtask
   // Undriven mode-select is driven low here to prove the pull-up
   task automatic tap_reset(input logic flt);
      logic o;
      logic e;
      tms_driven <= !flt;
      for (int i = 0; i < 5; i++)
         step(!flt, ~tdi, o, e);
      tms_driven <= 1'b1;
      step(1'b0, ~tdi, o, e);
   endtask
   task automatic scan(input logic ir, input int n, input logic [79:0] din,
      output logic [79:0] dout, output int bad);
      logic o;
      logic e;
      bad = 0;
      dout = 80'h0;
      step(1'b1, ~tdi, o, e);
      if (ir)
         step(1'b1, ~tdi, o, e);
      step(1'b0, ~tdi, o, e);
      step(1'b0, ~tdi, o, e);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], o, e);
         dout[i] = o;
         bad += (e !== 1'b0);
      end
      step(1'b1, ~tdi, o, e);
      step(1'b0, ~tdi, o, e);
      bad += (e !== 1'b1);
   endtask
endmodule

// file: sram_boundary_scan_tap_bench.sv
/*
 Self-checking bench of the scan test port with a board controller model.
 Assumes the checker is bound into the design.
*/
`timescale 1ns/1ps
module sram_boundary_scan_tap_bench;
   logic clk, rst_b, tck, tms, tms_driven, tdi, tdi_driven;
   logic memory_clock_true, memory_clock_comp;
   logic [tap_pkg::BSR_WIDTH-3:0] ring_in;
   logic tdo, tdo_oe_b, mem_outputs_hiz, o, e;
   logic [79:0] v, q;
   logic [31:0] lfsr;
   int errors, cmp_count, bad, len;
   // No reserved codes are ever loaded
   logic [2:0] codes [5] = '{tap_pkg::INSTR_EXTEST,
      tap_pkg::INSTR_SAMPLE_Z, tap_pkg::INSTR_SAMPLE,
      tap_pkg::INSTR_BYPASS, tap_pkg::INSTR_IDCODE};
   sram_boundary_scan_tap dut (.clk, .rst_b, .tck, .tms, .tms_driven,
      .tdi, .tdi_driven, .memory_clock_true, .memory_clock_comp, .ring_in,
      .tdo, .tdo_oe_b, .mem_outputs_hiz);
   jtag_host_model host (.tck, .tms, .tms_driven, .tdi, .tdi_driven,
      .tdo, .tdo_oe_b);
   function automatic logic [79:0] id_val();
      return 80'({tap_pkg::ID_REVISION, tap_pkg::ID_DEVICE,
         tap_pkg::ID_VENDOR, tap_pkg::ID_PRESENT});
   endfunction
   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic rnd80(output logic [79:0] r);
      repeat (3)
      begin
         lfsr = lfsr_step(lfsr);
         r = {r[47:0], lfsr};
      end
   endtask
   task automatic check(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1)
      begin
         errors++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   task automatic close_out;
      if (errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Eight extra bits show the path length and the shifted-in data
   task automatic run_dr(input int n, input logic [79:0] cap);
      logic [79:0] d;
      logic [79:0] r;
      int b;
      rnd80(d);
      host.scan(1'b0, n + 8, d, r, b);
      check((r & ((80'h1 << n) - 80'h1)) === cap, "captured value");
      check(8'(r >> n) === d[7:0], "shift path");
      check(b == 0, "tdo enable");
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #500000;
      errors++;
      close_out();
   end
   initial
   begin
      errors = 0;
      cmp_count = 0;
      lfsr = 32'h0000_9712;
      rst_b = 1'b0;
      {memory_clock_true, memory_clock_comp, ring_in} = 69'h0;
      host.step(1'b1, 1'b1, o, e);
      @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      check(tdo_oe_b === 1'b1 && mem_outputs_hiz === 1'b0, "reset");
      // Controller leaves reset for idle before the first frame
      host.step(1'b0, 1'b1, o, e);
      run_dr(tap_pkg::ID_WIDTH, id_val());
      for (int i = 0; i < 5; i++)
      begin
         host.tap_reset(i[0]);
         repeat (3) @(posedge clk);
         check(mem_outputs_hiz === 1'b0, "float after reset");
         rnd80(v);
         {memory_clock_true, memory_clock_comp, ring_in} <= v[68:0];
         host.scan(1'b1, 3, {77'h0, codes[i]}, q, bad);
         check(q[2:0] === 3'h1, "ir capture");
         check(bad == 0, "ir tdo enable");
         repeat (3) @(posedge clk);
         check(mem_outputs_hiz === (i < 2), "float");
         len = i < 3 ? tap_pkg::BSR_WIDTH : (i == 3 ? 1 : 32);
         run_dr(len, i < 3 ? 80'(v[68:0]) : (i == 3 ? 80'h0 : id_val()));
      end
      host.tap_reset(1'b0);
      host.scan(1'b1, 3, {77'h0, tap_pkg::INSTR_BYPASS}, q, bad);
      check(bad == 0, "ir tdo enable");
      host.tdi_driven <= 1'b0;
      host.scan(1'b0, 9, 80'h0, q, bad);
      check(q[8:0] === 9'h1FE, "tdi pull-up");
      check(bad == 0, "bypass tdo enable");
      host.tdi_driven <= 1'b1;
      host.tap_reset(1'b1);
      run_dr(tap_pkg::ID_WIDTH, id_val());
      close_out();
   end
endmodule
